// ===== rtl/umb_defines.svh
// Purpose: Offsets, field positions, reset values for the USB mailbox/FIFO irq block
// Assumes: Printed offsets are register indices; byte address is four times the index
// Notes: Definitions only
`ifndef UMB_DEFINES_SVH
`define UMB_DEFINES_SVH

// ==========================================================
// Register indices
`define UMB_IDX_FIFO_EN_B 16'h4006
`define UMB_IDX_FIFO_ST_B 16'h4008
`define UMB_IDX_RX_INDEX 16'h4010
`define UMB_IDX_RX_DATA 16'h4012
`define UMB_IDX_TX_INDEX 16'h4018
`define UMB_IDX_TX_DATA 16'h401a
`define UMB_IDX_MBX_ST 16'h4030
`define UMB_IDX_MBX_EN 16'h4032

// ==========================================================
// Bus geometry
`define UMB_ADDR_W 20
`define UMB_BYTE_ADDR(i) ({2'b00, (i), 2'b00})

// ==========================================================
// Fields
`define UMB_BANK_W 2
`define UMB_BIT_RX_ALMOST_FULL 0
`define UMB_BIT_TX_ALMOST_EMPTY 1
`define UMB_BIT_RX_MBOX_WRITTEN 0
`define UMB_BIT_TX_MBOX_READ 1
`define UMB_IDX_W 3
`define UMB_MBOX_DEPTH 8
`define UMB_BYTE_W 8

// ==========================================================
// Reset values
`define UMB_RST_BANK 2'h0
`define UMB_RST_INDEX 3'h0
`define UMB_RST_DATA16 16'h0000
`define UMB_RST_BYTE 8'h00

`endif

// ===== rtl/umb_pkg.sv
// Purpose: Types shared by the USB mailbox/FIFO irq block
// Assumes: umb_defines.svh holds the bank, index and byte widths
// Notes: Types only
`include "umb_defines.svh"

package umb_pkg;

  // ==========================================================
  // Register selection
  typedef enum logic [3:0] {
    UMB_SEL_NONE,
    UMB_SEL_FIFO_EN_B,
    UMB_SEL_FIFO_ST_B,
    UMB_SEL_RX_INDEX,
    UMB_SEL_RX_DATA,
    UMB_SEL_TX_INDEX,
    UMB_SEL_TX_DATA,
    UMB_SEL_MBX_ST,
    UMB_SEL_MBX_EN
  } umb_sel_t;

  // ==========================================================
  // State of one status/enable bank
  typedef struct packed {
    logic [`UMB_BANK_W-1:0] status;
    logic [`UMB_BANK_W-1:0] enable;
  } umb_bank_t;

  // ==========================================================
  // State of the register core
  typedef struct packed {
    logic [`UMB_IDX_W-1:0] rx_idx;
    logic [`UMB_IDX_W-1:0] tx_idx;
    logic [15:0] prdata;
    logic pslverr;
    logic [`UMB_BYTE_W-1:0] usb_data;
  } umb_core_t;

endpackage

// ===== rtl/umb_irq_bank.sv
// Purpose: Sticky status bits with enable mask and one level irq
// Assumes: Events are one-cycle pulses on the same clock
// Notes: Set wins over a write-one clear in the same cycle
`timescale 1ns/1ns
`include "umb_defines.svh"

module umb_irq_bank
(
  input wire logic CORE_CLK, // System clock
  input wire logic NRST, // Async reset, active low
  input wire logic [`UMB_BANK_W-1:0] set, // Event pulses
  input wire logic st_wr, // Status write strobe
  input wire logic en_wr, // Enable write strobe
  input wire logic [`UMB_BANK_W-1:0] wdata, // Write data
  output logic [`UMB_BANK_W-1:0] status, // Sticky flags
  output logic [`UMB_BANK_W-1:0] enable, // Enable bits
  output logic irq // Any enabled flag set
);
  import umb_pkg::*;

  umb_bank_t st;
  umb_bank_t next_st;

  always_comb
  begin
    next_st = st;
    if (en_wr)
    begin
      next_st.enable = wdata;
    end
    // Clear by one, then set so an event in the clear cycle survives
    next_st.status = (st.status & ~(st_wr ? wdata : `UMB_RST_BANK)) | set;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st <= '{status: `UMB_RST_BANK, enable: `UMB_RST_BANK};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign enable = st.enable;
  assign irq = |(st.status & st.enable);

endmodule

// ===== rtl/umb_mbox8.sv
// Purpose: Small byte mailbox, one write port, two read ports
// Assumes: Write and read addresses come from logic on the same clock
// Notes: Reads are combinational from flops
`timescale 1ns/1ns
`include "umb_defines.svh"

module umb_mbox8 #(
  parameter int DW = `UMB_BYTE_W,
  parameter int DEPTH = `UMB_MBOX_DEPTH,
  parameter int AW = `UMB_IDX_W
)
(
  input wire logic CORE_CLK, // System clock
  input wire logic NRST, // Async reset, active low
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write entry
  input wire logic [DW-1:0] wdata, // Write byte
  input wire logic [AW-1:0] raddr_a, // Read entry A
  output logic [DW-1:0] rdata_a, // Read byte A
  input wire logic [AW-1:0] raddr_b, // Read entry B
  output logic [DW-1:0] rdata_b // Read byte B
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
  } umb_mbox_t;

  umb_mbox_t st;
  umb_mbox_t next_st;

  always_comb
  begin
    next_st = st;
    if (we)
    begin
      next_st.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata_a = st.mem[raddr_a];
  assign rdata_b = st.mem[raddr_b];

endmodule

// ===== rtl/umb_core.sv
// Purpose: APB register core for USB mailboxes and FIFO level interrupts
// Assumes: FIFO counters and USB endpoint engine run on CORE_CLK
// Notes: Zero-wait APB; printed offsets are indices, byte address = 4 x index
//
// Behaviour
// - The transmit almost-empty flag sets when a byte leaves the FIFO while its count equals the threshold.
// - Writing one to a status flag clears it; writing zero leaves it alone.
// - The endpoint 1 index picks which receive mailbox byte a data port read returns.
// - Each read of the endpoint 1 data port advances its index by one, wrapping from 7 to 0.
// - The endpoint 1 data port is read-only and returns the byte at the current index.
// - Eight receive mailbox bytes are loaded by USB bulk OUT writes to endpoint 1.
// - A USB host write into the receive mailbox can raise an enabled irq to the CPU.
// - The read/write endpoint 2 index picks which transmit mailbox byte a CPU data port access uses.
// - Each read, or each write with the low byte lane strobed, of the endpoint 2 data port advances its index by one, wrapping from 7 to 0.
// - A summary output is high whenever any flag of the FIFO status register is set.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "umb_defines.svh"

module umb_core
(
  input wire logic CORE_CLK, // 20 MHz system clock
  input wire logic NRST, // Async reset, active low
  // APB slave
  input wire logic PSEL, // Slave select
  input wire logic PENABLE, // Access phase
  input wire logic PWRITE, // Write when high
  input wire logic [`UMB_ADDR_W-1:0] PADDR, // Byte address
  input wire logic [31:0] PWDATA, // Write data
  input wire logic [3:0] PSTRB, // Byte lane strobes
  output logic [31:0] PRDATA, // Read data
  output logic PREADY, // Transfer done
  output logic PSLVERR, // Unmapped address
  // FIFO side
  input wire logic [`UMB_BYTE_W-1:0] TX_FIFO_COUNT, // Transmit FIFO fill
  input wire logic [`UMB_BYTE_W-1:0] TX_ALMOST_EMPTY_THR, // Almost-empty threshold
  input wire logic TX_FIFO_POP, // Byte sent to USB, pulse
  input wire logic RX_ALMOST_FULL_EVT, // Receive almost-full, pulse
  // USB endpoint engine
  input wire logic RX_MBOX_WR, // Host writes rx mailbox, pulse
  input wire logic [`UMB_IDX_W-1:0] RX_MBOX_ADDR, // Rx mailbox entry
  input wire logic [`UMB_BYTE_W-1:0] RX_MBOX_WDATA, // Rx mailbox byte
  input wire logic TX_MBOX_RD, // Host reads tx mailbox, pulse
  input wire logic [`UMB_IDX_W-1:0] TX_MBOX_ADDR, // Tx mailbox entry
  output logic [`UMB_BYTE_W-1:0] TX_MBOX_RDATA, // Tx byte, next cycle
  // Interrupt
  output logic IRQ, // Level, any enabled flag
  output logic FIFO_IRQ_ACTIVE // Summary of FIFO flags
);
  import umb_pkg::*;

  // ==========================================================
  // Address decode
  function automatic umb_sel_t umb_decode(input logic [`UMB_ADDR_W-1:0] a);
    umb_sel_t s;
    s = UMB_SEL_NONE;
    if (a == `UMB_BYTE_ADDR(`UMB_IDX_FIFO_EN_B))
    begin
      s = UMB_SEL_FIFO_EN_B;
    end
    else if (a == `UMB_BYTE_ADDR(`UMB_IDX_FIFO_ST_B))
    begin
      s = UMB_SEL_FIFO_ST_B;
    end
    else if (a == `UMB_BYTE_ADDR(`UMB_IDX_RX_INDEX))
    begin
      s = UMB_SEL_RX_INDEX;
    end
    else if (a == `UMB_BYTE_ADDR(`UMB_IDX_RX_DATA))
    begin
      s = UMB_SEL_RX_DATA;
    end
    else if (a == `UMB_BYTE_ADDR(`UMB_IDX_TX_INDEX))
    begin
      s = UMB_SEL_TX_INDEX;
    end
    else if (a == `UMB_BYTE_ADDR(`UMB_IDX_TX_DATA))
    begin
      s = UMB_SEL_TX_DATA;
    end
    else if (a == `UMB_BYTE_ADDR(`UMB_IDX_MBX_ST))
    begin
      s = UMB_SEL_MBX_ST;
    end
    else if (a == `UMB_BYTE_ADDR(`UMB_IDX_MBX_EN))
    begin
      s = UMB_SEL_MBX_EN;
    end
    return s;
  endfunction

  // Index step, wrapping 7 back to 0
  function automatic logic [`UMB_IDX_W-1:0] umb_step(input logic [`UMB_IDX_W-1:0] i);
    return i + `UMB_IDX_W'(1);
  endfunction

  // ==========================================================
  // Declarations
  umb_core_t st;
  umb_core_t next_st;
  umb_sel_t sel;
  logic setup;
  logic access;
  logic wr_lo;
  logic rd_done;
  logic [`UMB_BANK_W-1:0] fifo_set;
  logic [`UMB_BANK_W-1:0] fifo_status;
  logic [`UMB_BANK_W-1:0] fifo_enable;
  logic fifo_irq;
  logic [`UMB_BANK_W-1:0] mbx_set;
  logic [`UMB_BANK_W-1:0] mbx_status;
  logic [`UMB_BANK_W-1:0] mbx_enable;
  logic mbx_irq;
  logic [`UMB_BYTE_W-1:0] rx_byte;
  logic [`UMB_BYTE_W-1:0] tx_cpu_byte;
  logic [`UMB_BYTE_W-1:0] tx_usb_byte;
  logic tx_mbox_we;
  logic tx_almost_empty_evt;

  // ==========================================================
  // Bus phases
  assign sel = umb_decode(PADDR);
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  // Only the low byte lane holds data; upper lanes are ignored
  assign wr_lo = access & PWRITE & PSTRB[0];
  assign rd_done = access & ~PWRITE;

  // ==========================================================
  // Events
  // Count still equals threshold as the byte leaves, so the fill drops below it
  assign tx_almost_empty_evt = TX_FIFO_POP & (TX_FIFO_COUNT == TX_ALMOST_EMPTY_THR);

  always_comb
  begin
    fifo_set = `UMB_RST_BANK;
    fifo_set[`UMB_BIT_RX_ALMOST_FULL] = RX_ALMOST_FULL_EVT;
    fifo_set[`UMB_BIT_TX_ALMOST_EMPTY] = tx_almost_empty_evt;
    mbx_set = `UMB_RST_BANK;
    mbx_set[`UMB_BIT_RX_MBOX_WRITTEN] = RX_MBOX_WR;
    mbx_set[`UMB_BIT_TX_MBOX_READ] = TX_MBOX_RD;
  end

  // ==========================================================
  // Interrupt banks
  umb_irq_bank u_fifo_bank (
    .CORE_CLK(CORE_CLK),
    .NRST(NRST),
    .set(fifo_set),
    .st_wr(wr_lo && sel == UMB_SEL_FIFO_ST_B),
    .en_wr(wr_lo && sel == UMB_SEL_FIFO_EN_B),
    .wdata(PWDATA[`UMB_BANK_W-1:0]),
    .status(fifo_status),
    .enable(fifo_enable),
    .irq(fifo_irq)
  );

  umb_irq_bank u_mbx_bank (
    .CORE_CLK(CORE_CLK),
    .NRST(NRST),
    .set(mbx_set),
    .st_wr(wr_lo && sel == UMB_SEL_MBX_ST),
    .en_wr(wr_lo && sel == UMB_SEL_MBX_EN),
    .wdata(PWDATA[`UMB_BANK_W-1:0]),
    .status(mbx_status),
    .enable(mbx_enable),
    .irq(mbx_irq)
  );

  // ==========================================================
  // Mailboxes
  // Receive: filled by the host, read by the CPU at its index
  umb_mbox8 u_rx_mbox (
    .CORE_CLK(CORE_CLK),
    .NRST(NRST),
    .we(RX_MBOX_WR),
    .waddr(RX_MBOX_ADDR),
    .wdata(RX_MBOX_WDATA),
    .raddr_a(st.rx_idx),
    .rdata_a(rx_byte),
    .raddr_b(RX_MBOX_ADDR),
    .rdata_b()
  );

  // Transmit: filled by the CPU at its index, read by the host
  assign tx_mbox_we = wr_lo && sel == UMB_SEL_TX_DATA;

  umb_mbox8 u_tx_mbox (
    .CORE_CLK(CORE_CLK),
    .NRST(NRST),
    .we(tx_mbox_we),
    .waddr(st.tx_idx),
    .wdata(PWDATA[`UMB_BYTE_W-1:0]),
    .raddr_a(st.tx_idx),
    .rdata_a(tx_cpu_byte),
    .raddr_b(TX_MBOX_ADDR),
    .rdata_b(tx_usb_byte)
  );

  // ==========================================================
  // Register core
  always_comb
  begin
    next_st = st;
    // Read data is captured in the setup cycle so the access phase never waits
    if (setup)
    begin
      next_st.pslverr = (sel == UMB_SEL_NONE);
      next_st.prdata = `UMB_RST_DATA16;
      if (sel == UMB_SEL_FIFO_EN_B)
      begin
        next_st.prdata[`UMB_BANK_W-1:0] = fifo_enable;
      end
      else if (sel == UMB_SEL_FIFO_ST_B)
      begin
        next_st.prdata[`UMB_BANK_W-1:0] = fifo_status;
      end
      else if (sel == UMB_SEL_RX_INDEX)
      begin
        next_st.prdata[`UMB_IDX_W-1:0] = st.rx_idx;
      end
      else if (sel == UMB_SEL_RX_DATA)
      begin
        next_st.prdata[`UMB_BYTE_W-1:0] = rx_byte;
      end
      else if (sel == UMB_SEL_TX_INDEX)
      begin
        next_st.prdata[`UMB_IDX_W-1:0] = st.tx_idx;
      end
      else if (sel == UMB_SEL_TX_DATA)
      begin
        next_st.prdata[`UMB_BYTE_W-1:0] = tx_cpu_byte;
      end
      else if (sel == UMB_SEL_MBX_ST)
      begin
        next_st.prdata[`UMB_BANK_W-1:0] = mbx_status;
      end
      else if (sel == UMB_SEL_MBX_EN)
      begin
        next_st.prdata[`UMB_BANK_W-1:0] = mbx_enable;
      end
    end
    // Receive index is read-only; writes to it and its data port are dropped
    if (rd_done && sel == UMB_SEL_RX_DATA)
    begin
      next_st.rx_idx = umb_step(st.rx_idx);
    end
    if (wr_lo && sel == UMB_SEL_TX_INDEX)
    begin
      next_st.tx_idx = PWDATA[`UMB_IDX_W-1:0];
    end
    // Write needs the low lane to count as an access of the port
    else if ((rd_done || wr_lo) && sel == UMB_SEL_TX_DATA)
    begin
      next_st.tx_idx = umb_step(st.tx_idx);
    end
    next_st.usb_data = TX_MBOX_RD ? tx_usb_byte : st.usb_data;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st <= '{rx_idx: `UMB_RST_INDEX, tx_idx: `UMB_RST_INDEX, prdata: `UMB_RST_DATA16,
              pslverr: 1'b0, usb_data: `UMB_RST_BYTE};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign PREADY = 1'b1;
  assign PRDATA = {16'h0000, st.prdata};
  assign PSLVERR = access & st.pslverr;
  assign TX_MBOX_RDATA = st.usb_data;
  assign IRQ = fifo_irq | mbx_irq;
  assign FIFO_IRQ_ACTIVE = |fifo_status;

endmodule

// ===== verification/umb_core_monitor.sv
// Purpose: Port-level checks of umb_core
// Assumes: Zero-wait APB, one clock domain
// Notes: Bound to every umb_core instance
`timescale 1ns/1ns
`include "umb_defines.svh"

// ==========================================================
// Checker
module umb_core_monitor
(
  input wire logic CORE_CLK, // Clock
  input wire logic NRST, // Reset, active low
  input wire logic PSEL, // Select
  input wire logic PENABLE, // Access phase
  input wire logic PWRITE, // Direction
  input wire logic [`UMB_ADDR_W-1:0] PADDR, // Address
  input wire logic [31:0] PWDATA, // Write data
  input wire logic [3:0] PSTRB, // Strobes
  input wire logic [`UMB_BYTE_W-1:0] TX_FIFO_COUNT, // Fill
  input wire logic [`UMB_BYTE_W-1:0] TX_ALMOST_EMPTY_THR, // Threshold
  input wire logic TX_FIFO_POP, // Byte sent
  input wire logic RX_ALMOST_FULL_EVT, // Rx event
  input wire logic RX_MBOX_WR, // Host write
  input wire logic TX_MBOX_RD, // Host read
  input wire logic [`UMB_BYTE_W-1:0] TX_MBOX_RDATA, // Host byte
  input wire logic IRQ, // Interrupt
  input wire logic FIFO_IRQ_ACTIVE // Summary
);
  logic st_wr;
  logic evt;

  assign st_wr = PSEL && PENABLE && PWRITE && PSTRB[0] && PADDR == `UMB_BYTE_ADDR(`UMB_IDX_FIFO_ST_B);
  assign evt = TX_FIFO_POP && TX_FIFO_COUNT == TX_ALMOST_EMPTY_THR;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  AST_TXAE_SET: assert property (evt |=> FIFO_IRQ_ACTIVE)
    else $error("tx almost-empty flag not set");
  AST_RXAF_SET: assert property (RX_ALMOST_FULL_EVT |=> FIFO_IRQ_ACTIVE)
    else $error("summary not set by rx event");
  AST_NO_CAUSE: assert property (!FIFO_IRQ_ACTIVE && !evt && !RX_ALMOST_FULL_EVT |=> !FIFO_IRQ_ACTIVE)
    else $error("flag set without its event");
  AST_W1C: assert property (st_wr && PWDATA[1:0] == 2'b11 && !TX_FIFO_POP && !RX_ALMOST_FULL_EVT
    |=> !FIFO_IRQ_ACTIVE)
    else $error("write one did not clear");
  AST_W0_KEEP: assert property (FIFO_IRQ_ACTIVE && st_wr && PWDATA[1:0] == 2'b00 |=> FIFO_IRQ_ACTIVE)
    else $error("write zero cleared a flag");
  AST_STICKY: assert property (FIFO_IRQ_ACTIVE && !st_wr |=> FIFO_IRQ_ACTIVE)
    else $error("flag dropped without a write");
  AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> $past(TX_FIFO_POP || RX_ALMOST_FULL_EVT || RX_MBOX_WR
    || TX_MBOX_RD || (PSEL && PENABLE && PWRITE)))
    else $error("irq rose with no cause");
  AST_TXMB_HOLD: assert property (!TX_MBOX_RD |=> $stable(TX_MBOX_RDATA))
    else $error("host byte changed without a read");
endmodule

bind umb_core umb_core_monitor u_mon (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .TX_FIFO_COUNT(TX_FIFO_COUNT),
  .TX_ALMOST_EMPTY_THR(TX_ALMOST_EMPTY_THR), .TX_FIFO_POP(TX_FIFO_POP), .RX_ALMOST_FULL_EVT(RX_ALMOST_FULL_EVT),
  .RX_MBOX_WR(RX_MBOX_WR), .TX_MBOX_RD(TX_MBOX_RD), .TX_MBOX_RDATA(TX_MBOX_RDATA), .IRQ(IRQ),
  .FIFO_IRQ_ACTIVE(FIFO_IRQ_ACTIVE));

// ===== verification/umb_usb_host_model.sv
// Purpose: Host and FIFO side stand-in for umb_core
// Assumes: Pulses last one clock
// Notes: Released lines toggle so stale values never match
`timescale 1ns/1ns

// ==========================================================
// Model
module umb_usb_host_model
(
  input wire logic clk, // System clock
  input wire logic [7:0] tx_rdata, // Byte from tx mailbox
  output logic rx_wr, // Rx mailbox write
  output logic [2:0] rx_addr, // Rx entry
  output logic [7:0] rx_wdata, // Rx byte
  output logic tx_rd, // Tx mailbox read
  output logic [2:0] tx_addr, // Tx entry
  output logic [7:0] fifo_count, // Tx fill
  output logic [7:0] fifo_thr, // Threshold
  output logic fifo_pop, // Byte sent
  output logic rx_full // Rx almost full
);
  initial
  begin
    {rx_wr, rx_addr, rx_wdata, tx_rd, tx_addr, fifo_pop, rx_full} = '0;
    fifo_count = 8'h10;
    fifo_thr = 8'h04;
  end

  task automatic host_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    rx_wr <= 1'b1;
    rx_addr <= a;
    rx_wdata <= d;
    @(posedge clk);
    rx_wr <= 1'b0;
    rx_addr <= ~a;
    rx_wdata <= ~d;
  endtask

  task automatic host_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    tx_rd <= 1'b1;
    tx_addr <= a;
    @(posedge clk);
    tx_rd <= 1'b0;
    tx_addr <= ~a;
    @(posedge clk);
    d = tx_rdata;
  endtask

  task automatic pop(input logic [7:0] cnt, input logic [7:0] thr);
    @(posedge clk);
    fifo_pop <= 1'b1;
    fifo_count <= cnt;
    fifo_thr <= thr;
    @(posedge clk);
    fifo_pop <= 1'b0;
    fifo_count <= cnt - 8'h01;
  endtask

  task automatic almost_full();
    @(posedge clk);
    rx_full <= 1'b1;
    @(posedge clk);
    rx_full <= 1'b0;
  endtask
endmodule

// ===== verification/umb_usb_mailbox_index_fifo_irq_tb_top.sv
// Purpose: Self-checking bench of umb_core
// Assumes: APB answers with PREADY in the first access cycle; any wait state fails a check
// Notes: Host side comes from umb_usb_host_model
`timescale 1ns/1ns
`include "umb_defines.svh"

// ==========================================================
// Bench
module umb_usb_mailbox_index_fifo_irq_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`UMB_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h1;
  logic [31:0] prdata;
  logic pready, pslverr, rx_wr, tx_rd, pop, full, irq, active;
  logic [2:0] rx_addr, tx_addr;
  logic [7:0] rx_wdata, tx_rdata, cnt, thr, b;
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int cmp_count = 0;

  initial
  begin
    forever #25 clk = ~clk;
  end

  umb_core u_dut (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_FIFO_COUNT(cnt), .TX_ALMOST_EMPTY_THR(thr), .TX_FIFO_POP(pop), .RX_ALMOST_FULL_EVT(full),
    .RX_MBOX_WR(rx_wr), .RX_MBOX_ADDR(rx_addr), .RX_MBOX_WDATA(rx_wdata), .TX_MBOX_RD(tx_rd),
    .TX_MBOX_ADDR(tx_addr), .TX_MBOX_RDATA(tx_rdata), .IRQ(irq), .FIFO_IRQ_ACTIVE(active));

  umb_usb_host_model u_host (.clk(clk), .tx_rdata(tx_rdata), .rx_wr(rx_wr), .rx_addr(rx_addr),
    .rx_wdata(rx_wdata), .tx_rd(tx_rd), .tx_addr(tx_addr), .fifo_count(cnt), .fifo_thr(thr),
    .fifo_pop(pop), .rx_full(full));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= `UMB_BYTE_ADDR(idx);
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(n), 32'h1, "apb wait states");
    // Let a committed write reach flags and irq before anyone looks
    @(posedge clk);
  endtask

  task automatic t_reset();
    logic [15:0] regs [5] = '{`UMB_IDX_FIFO_EN_B, `UMB_IDX_FIFO_ST_B, `UMB_IDX_RX_INDEX, `UMB_IDX_RX_DATA,
      `UMB_IDX_TX_INDEX};
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 32'h0);
      check(rd, 32'h0, "reset value");
    end
    apb(1'b0, 16'h4002, 32'h0);
    check(rd, 32'h0, "unmapped read data");
    check({31'h0, er}, 32'h1, "unmapped read error");
    $display("test reset done");
  endtask

  task automatic t_rx_mbox();
    apb(1'b1, `UMB_IDX_MBX_EN, 32'h1);
    for (int i = 0; i < 8; i++)
      u_host.host_write(i[2:0], 8'hc0 + i[7:0]);
    check(irq, 1'b1, "host write irq");
    apb(1'b1, `UMB_IDX_MBX_ST, 32'h1);
    check(irq, 1'b0, "mailbox irq cleared");
    apb(1'b1, `UMB_IDX_RX_INDEX, 32'h5);
    apb(1'b0, `UMB_IDX_RX_INDEX, 32'h0);
    // Reset test read the data port once, so the index stands at 1
    check(rd, 32'h1, "rx index read-only");
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, `UMB_IDX_RX_DATA, 32'h0);
      check(rd, {24'h0, 8'hc0 + 8'((i + 1) % 8)}, "rx mailbox byte");
    end
    apb(1'b0, `UMB_IDX_RX_INDEX, 32'h0);
    check(rd, 32'h2, "rx index wrapped");
    $display("test rx mailbox done");
  endtask

  task automatic t_tx_mbox();
    apb(1'b1, `UMB_IDX_TX_INDEX, 32'h6);
    apb(1'b0, `UMB_IDX_TX_INDEX, 32'h0);
    check(rd, 32'h6, "tx index write");
    for (int i = 0; i < 8; i++)
      apb(1'b1, `UMB_IDX_TX_DATA, 32'h30 + i);
    apb(1'b0, `UMB_IDX_TX_INDEX, 32'h0);
    check(rd, 32'h6, "tx index wrapped");
    // No low lane: the write must neither land in entry 6 nor step the index
    pstrb <= 4'h0;
    apb(1'b1, `UMB_IDX_TX_DATA, 32'hff);
    pstrb <= 4'h1;
    apb(1'b0, `UMB_IDX_TX_INDEX, 32'h0);
    check(rd, 32'h6, "strobe-less write ignored");
    for (int j = 0; j < 8; j++)
    begin
      u_host.host_read(j[2:0], b);
      check(b, 8'h30 + 8'((j + 2) % 8), "host byte");
    end
    apb(1'b0, `UMB_IDX_TX_DATA, 32'h0);
    check(rd, 32'h30, "cpu tx read");
    apb(1'b0, `UMB_IDX_TX_INDEX, 32'h0);
    check(rd, 32'h7, "tx index after read");
    $display("test tx mailbox done");
  endtask

  task automatic t_fifo();
    apb(1'b1, `UMB_IDX_FIFO_EN_B, 32'h2);
    u_host.pop(8'h05, 8'h03);
    apb(1'b0, `UMB_IDX_FIFO_ST_B, 32'h0);
    check(rd, 32'h0, "pop above threshold");
    u_host.pop(8'h03, 8'h03);
    apb(1'b0, `UMB_IDX_FIFO_ST_B, 32'h0);
    check(rd, 32'h2, "pop at threshold");
    check({irq, active}, 2'b11, "almost-empty irq");
    apb(1'b1, `UMB_IDX_FIFO_ST_B, 32'h0);
    apb(1'b0, `UMB_IDX_FIFO_ST_B, 32'h0);
    check(rd, 32'h2, "write zero keeps");
    apb(1'b1, `UMB_IDX_FIFO_ST_B, 32'h2);
    check({irq, active}, 2'b00, "write one clears");
    u_host.almost_full();
    apb(1'b0, `UMB_IDX_FIFO_ST_B, 32'h0);
    check({rd[1:0], irq, active}, 4'b0101, "masked rx flag");
    apb(1'b1, `UMB_IDX_FIFO_EN_B, 32'h1);
    check(irq, 1'b1, "rx almost-full irq");
    apb(1'b1, `UMB_IDX_FIFO_ST_B, 32'h3);
    check({irq, active}, 2'b00, "rx flag cleared");
    $display("test fifo irq done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_rx_mbox();
    t_tx_mbox();
    t_fifo();
    results();
  end
endmodule
